// [pcd_change_detect.sv]
// Port C pin change detector with an AXI4-Lite register slave.
// Assumes pins are asynchronous to aclk and the wake controller samples wake_req.
//
// Functional notes
// [R01] Writable falling-edge enable, one bit per pin.
// [R02] Enabled falling edge sets the pin flag.
// [R03] Enabled rising edge sets the pin flag.
// [R04] Pin flag and shared flag set together.
// [R05] Disabled edge direction never sets a flag.
// [R06] Hardware only sets flags; software clears with zero.
// [R07] Enables and flags reset to zero.
// [R08] Pins 7 and 6 only on large variant.
// [R09] Unimplemented bits read zero, ignore writes.
// [R10] Writable rising-edge enable, one bit per pin.
// [R11] Change wakes device when interrupt enable set.
// [R12] Flags update before first instruction after wake.
// [R13] Software clears flags by masked AND.
// [R14] Synchronised sampling; hardware set beats clear.
// [R15] Shared flag is OR of all flags.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pcd_defines.svh"

module pcd_change_detect #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire pcd_pkg::pcd_axi_req_t axi_req,
  output pcd_pkg::pcd_axi_rsp_t axi_rsp,
  input wire logic [7:0] third_port_pin,
  output logic shared_change_irq_flag,
  output logic wake_req,
  output logic irq
);
  import pcd_pkg::*;

  // Pins 7 and 6 exist only on the larger package; elsewhere they are tied off.
  localparam logic [7:0] IMPL_MASK = LARGE_VARIANT ? 8'hff : 8'h3f; // R08

  logic [7:0] pin_meta_ff, pin_sync_ff, pin_prev_ff;
  logic [7:0] portc_rise_edge_enable_ff, portc_fall_edge_enable_ff;
  logic [7:0] portc_change_flags_ff, nxt_portc_change_flags;
  logic shared_change_irq_enable_ff;
  logic irq_stat_ff, irq_en_ff, nxt_irq_stat;
  logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
  logic [`PCD_ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic w_lane_ff;

  // The first stage feeds only the second; all edge logic looks at later stages.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_ff <= `PCD_RST_BYTE;
      pin_sync_ff <= `PCD_RST_BYTE;
      pin_prev_ff <= `PCD_RST_BYTE;
    end else begin
      pin_meta_ff <= third_port_pin;
      pin_sync_ff <= pin_meta_ff; // R14
      pin_prev_ff <= pin_sync_ff;
    end
  end

  // One slice per pin; a pin outside the implemented mask never reports an edge.
  wire [`PCD_PINS-1:0] rise_seen;
  wire [`PCD_PINS-1:0] fall_seen;
  wire [`PCD_PINS-1:0] edge_hit;
  for (genvar i = 0; i < `PCD_PINS; i++) begin : g_pin
    assign rise_seen[i] = pin_sync_ff[i] && !pin_prev_ff[i]; // R14
    assign fall_seen[i] = !pin_sync_ff[i] && pin_prev_ff[i];
    assign edge_hit[i] = IMPL_MASK[i] && ((rise_seen[i] && portc_rise_edge_enable_ff[i]) // R03 R05
                         || (fall_seen[i] && portc_fall_edge_enable_ff[i])); // R02 R08
  end

  // Write channel: address and data are taken in either order and held until both arrive.
  wire aw_take = axi_req.awvalid && !aw_held_ff && !bvalid_ff;
  wire w_take = axi_req.wvalid && !w_held_ff && !bvalid_ff;
  wire have_aw = aw_held_ff || aw_take;
  wire have_w = w_held_ff || w_take;
  wire do_write = have_aw && have_w && !bvalid_ff;
  wire [`PCD_ADDR_W-1:0] wr_addr = aw_held_ff ? awaddr_ff : axi_req.awaddr;
  wire [31:0] wr_data = w_held_ff ? wdata_ff : axi_req.wdata;
  wire [7:0] wr_byte = wr_data[7:0] & IMPL_MASK;
  wire wr_lane0 = w_held_ff ? w_lane_ff : axi_req.wstrb[0];

  function automatic logic reg_mapped(input logic [`PCD_ADDR_W-1:0] a);
    reg_mapped = (a == `PCD_OFF_RISE_EN) || (a == `PCD_OFF_FALL_EN) || (a == `PCD_OFF_FLAGS)
              || (a == `PCD_OFF_CTRL) || (a == `PCD_OFF_IRQ_STAT) || (a == `PCD_OFF_IRQ_EN)
              || (a == `PCD_OFF_IRQ_CLR);
  endfunction

  wire wr_ok = do_write && wr_lane0;
  wire wr_rise = wr_ok && (wr_addr == `PCD_OFF_RISE_EN);
  wire wr_fall = wr_ok && (wr_addr == `PCD_OFF_FALL_EN);
  wire wr_flags = wr_ok && (wr_addr == `PCD_OFF_FLAGS);
  wire wr_ctrl = wr_ok && (wr_addr == `PCD_OFF_CTRL);
  wire wr_irq_en = wr_ok && (wr_addr == `PCD_OFF_IRQ_EN);
  wire wr_irq_clr = wr_ok && (wr_addr == `PCD_OFF_IRQ_CLR);

  // Only zeros written clear flags; ones leave them, so a masked AND never loses a new edge.
  wire [7:0] flag_keep = wr_flags ? wr_data[7:0] : 8'hff; // R06 R13
  assign nxt_portc_change_flags = ((portc_change_flags_ff & flag_keep) | edge_hit) & IMPL_MASK; // R14 R09

  wire change_any = |portc_change_flags_ff; // R15
  wire clr_stat = wr_irq_clr && wr_data[`PCD_STAT_CHANGE_BIT];
  assign nxt_irq_stat = (irq_stat_ff && !clr_stat) || (|edge_hit);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      portc_rise_edge_enable_ff <= `PCD_RST_BYTE; // R07
      portc_fall_edge_enable_ff <= `PCD_RST_BYTE;
      portc_change_flags_ff <= `PCD_RST_BYTE;
      shared_change_irq_enable_ff <= 1'b0;
      irq_stat_ff <= 1'b0;
      irq_en_ff <= 1'b0;
    end else begin
      if (wr_rise) begin
        portc_rise_edge_enable_ff <= wr_byte; // R10 R09
      end
      if (wr_fall) begin
        portc_fall_edge_enable_ff <= wr_byte; // R01 R09
      end
      if (wr_ctrl) begin
        shared_change_irq_enable_ff <= wr_data[`PCD_CTRL_IRQ_EN_BIT];
      end
      if (wr_irq_en) begin
        irq_en_ff <= wr_data[`PCD_STAT_CHANGE_BIT];
      end
      portc_change_flags_ff <= nxt_portc_change_flags; // R02 R03
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  // The shared flag follows the pin flags, so it rises on the same edge. R04
  assign shared_change_irq_flag = change_any; // R04 R15
  // Flags are already latched when wake is raised, ahead of any fetch. R12
  assign wake_req = change_any && shared_change_irq_enable_ff; // R11 R12
  assign irq = irq_stat_ff && irq_en_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `PCD_RESP_OKAY;
    end else begin
      if (do_write) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= reg_mapped(wr_addr) ? `PCD_RESP_OKAY : `PCD_RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held_ff <= 1'b1;
          awaddr_ff <= axi_req.awaddr;
        end
        if (w_take) begin
          w_held_ff <= 1'b1;
          wdata_ff <= axi_req.wdata;
        end
        if (bvalid_ff && axi_req.bready) begin
          bvalid_ff <= 1'b0;
        end
      end
    end
  end

  // A write whose low lane is not strobed is answered but changes nothing.
  // The strobe is held with the data, so a late address cannot turn such a write into a clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_lane_ff <= 1'b0;
    end else if (w_take && !do_write) begin
      w_lane_ff <= axi_req.wstrb[0];
    end
  end

  wire [31:0] ctrl_word = {30'h0, change_any, shared_change_irq_enable_ff};
  wire ar_take = axi_req.arvalid && !rvalid_ff;
  logic [31:0] rd_word;
  always_comb begin
    case (axi_req.araddr)
      `PCD_OFF_RISE_EN: rd_word = {24'h0, portc_rise_edge_enable_ff};
      `PCD_OFF_FALL_EN: rd_word = {24'h0, portc_fall_edge_enable_ff};
      `PCD_OFF_FLAGS: rd_word = {24'h0, portc_change_flags_ff}; // R09
      `PCD_OFF_CTRL: rd_word = ctrl_word;
      `PCD_OFF_IRQ_STAT: rd_word = {31'h0, irq_stat_ff};
      `PCD_OFF_IRQ_EN: rd_word = {31'h0, irq_en_ff};
      default: rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= `PCD_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= reg_mapped(axi_req.araddr) ? `PCD_RESP_OKAY : `PCD_RESP_SLVERR;
    end else if (rvalid_ff && axi_req.rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  always_comb begin
    axi_rsp = '0;
    axi_rsp.awready = !aw_held_ff && !bvalid_ff;
    axi_rsp.wready = !w_held_ff && !bvalid_ff;
    axi_rsp.bvalid = bvalid_ff;
    axi_rsp.bresp = bresp_ff;
    axi_rsp.arready = !rvalid_ff;
    axi_rsp.rvalid = rvalid_ff;
    axi_rsp.rdata = rdata_ff;
    axi_rsp.rresp = rresp_ff;
  end

  sequence rise_on_pin0;
    !pin_prev_ff[0] && pin_sync_ff[0] && portc_rise_edge_enable_ff[0];
  endsequence

  property flag_after_rise;
    @(posedge aclk) disable iff (!aresetn) rise_on_pin0 |=> portc_change_flags_ff[0];
  endproperty

  rise_sets_flag_a: assert property (flag_after_rise) // R03
    else $error("Enabled rising edge did not set flag 0.");

  fall_sets_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // R02
    (pin_prev_ff[1] && !pin_sync_ff[1] && portc_fall_edge_enable_ff[1]) |=> portc_change_flags_ff[1])
    else $error("Enabled falling edge did not set flag 1.");

  disabled_no_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // R05
    (!portc_change_flags_ff[2] && !edge_hit[2]) |=> !portc_change_flags_ff[2])
    else $error("Flag 2 rose without an enabled edge.");

  set_beats_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // R14
    (edge_hit[0] && wr_flags && !wr_data[0]) |=> portc_change_flags_ff[0])
    else $error("Software clear won over hardware set.");

  flag_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn) // R06
    (portc_change_flags_ff[3] && !(wr_flags && !wr_data[3])) |=> portc_change_flags_ff[3])
    else $error("Flag 3 dropped without a software clear.");

  shared_or_a: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    shared_change_irq_flag == (portc_change_flags_ff != 8'h00))
    else $error("Shared flag differs from OR of pin flags.");

  shared_with_pin_a: assert property (@(posedge aclk) disable iff (!aresetn) // R04
    (|edge_hit) |=> shared_change_irq_flag)
    else $error("Shared flag not set with pin flag.");

  unimpl_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // R09
    ((portc_change_flags_ff | portc_rise_edge_enable_ff | portc_fall_edge_enable_ff) & ~IMPL_MASK) == 8'h00)
    else $error("Unimplemented bit is set.");

  reset_clears_a: assert property (@(posedge aclk) // R07
    !aresetn |=> (portc_change_flags_ff == 8'h00 && portc_fall_edge_enable_ff == 8'h00))
    else $error("Reset left enables or flags set.");

  fall_en_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // R01
    wr_fall |=> portc_fall_edge_enable_ff == $past(wr_byte))
    else $error("Falling enable did not take the write.");

  rise_en_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    wr_rise |=> portc_rise_edge_enable_ff == $past(wr_byte))
    else $error("Rising enable did not take the write.");

  wake_follows_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    (|edge_hit && shared_change_irq_enable_ff && !wr_ctrl) |=> wake_req)
    else $error("Enabled change did not raise wake.");

  wake_has_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    wake_req |-> (portc_change_flags_ff != 8'h00))
    else $error("Wake raised before flags were latched.");

  small_variant_a: assert property (@(posedge aclk) disable iff (!aresetn) // R08
    !LARGE_VARIANT |-> (portc_change_flags_ff[7:6] == 2'b00))
    else $error("Pins 7 and 6 active on small variant.");

  // An answer on either response channel must stand until the master takes it.
  sequence write_waiting;
    bvalid_ff && !axi_req.bready;
  endsequence

  sequence read_waiting;
    rvalid_ff && !axi_req.rready;
  endsequence

  bresp_stands_a: assert property (@(posedge aclk) disable iff (!aresetn) // R01
    write_waiting |=> (axi_rsp.bvalid && $stable(axi_rsp.bresp)))
    else $error("Write response dropped before it was taken.");

  rdata_stands_a: assert property (@(posedge aclk) disable iff (!aresetn) // R09
    read_waiting |=> (axi_rsp.rvalid && $stable(axi_rsp.rdata)))
    else $error("Read data changed before it was taken.");

  write_answered_a: assert property (@(posedge aclk) disable iff (!aresetn) // R01
    do_write |=> axi_rsp.bvalid)
    else $error("Write was not answered.");

  read_answered_a: assert property (@(posedge aclk) disable iff (!aresetn) // R09
    ar_take |=> axi_rsp.rvalid)
    else $error("Read was not answered.");

  unmapped_error_a: assert property (@(posedge aclk) disable iff (!aresetn) // R09
    (ar_take && !reg_mapped(axi_req.araddr)) |=> (axi_rsp.rresp == `PCD_RESP_SLVERR && axi_rsp.rdata == 32'h0))
    else $error("Unmapped read not refused with zero data.");

  flag_clears_a: assert property (@(posedge aclk) disable iff (!aresetn) // R06
    (wr_flags && !wr_data[4] && !edge_hit[4]) |=> !portc_change_flags_ff[4])
    else $error("Zero written to flag 4 did not clear it.");

  strobe_off_keeps_a: assert property (@(posedge aclk) disable iff (!aresetn) // R06
    (do_write && !wr_lane0) |=> ($stable(portc_rise_edge_enable_ff) && $stable(portc_fall_edge_enable_ff)
      && ((~portc_change_flags_ff & $past(portc_change_flags_ff)) == 8'h00)))
    else $error("Unstrobed write changed a register.");

  irq_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn) // R04
    (irq_stat_ff && !clr_stat) |=> irq_stat_ff)
    else $error("Interrupt status dropped without a clear.");

  irq_clear_works_a: assert property (@(posedge aclk) disable iff (!aresetn) // R04
    (clr_stat && !(|edge_hit)) |=> !irq_stat_ff)
    else $error("Interrupt status survived its clear.");

  sync_two_stage_a: assert property (@(posedge aclk) disable iff (!aresetn) // R14
    ($past(aresetn) && $past(aresetn, 2)) |-> (pin_sync_ff == $past(third_port_pin, 2)))
    else $error("Synchronised pin does not lag the pin by two edges.");

  rise_reset_a: assert property (@(posedge aclk) // R07
    !aresetn |=> (portc_rise_edge_enable_ff == 8'h00 && !irq_stat_ff))
    else $error("Reset left rising enables or status set.");

  rise_off_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn) // R05
    (rise_seen[0] && !portc_rise_edge_enable_ff[0]) |-> !edge_hit[0])
    else $error("Disabled rising edge on pin 0 was reported.");

  fall_off_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn) // R05
    (fall_seen[5] && !portc_fall_edge_enable_ff[5]) |-> !edge_hit[5])
    else $error("Disabled falling edge on pin 5 was reported.");
endmodule
`default_nettype wire

// [pcd_defines.svh]
// Register offsets, field positions and reset values of the port C change detector.
// Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
`ifndef PCD_DEFINES_SVH
`define PCD_DEFINES_SVH

`define PCD_OFF_RISE_EN 5'h00
`define PCD_OFF_FALL_EN 5'h04
`define PCD_OFF_FLAGS 5'h08
`define PCD_OFF_CTRL 5'h0c
`define PCD_OFF_IRQ_STAT 5'h10
`define PCD_OFF_IRQ_EN 5'h14
`define PCD_OFF_IRQ_CLR 5'h18
`define PCD_ADDR_W 5
`define PCD_PINS 8
`define PCD_RST_BYTE 8'h00
`define PCD_CTRL_IRQ_EN_BIT 0
`define PCD_CTRL_IRQ_FLAG_BIT 1
`define PCD_STAT_CHANGE_BIT 0
`define PCD_RESP_OKAY 2'b00
`define PCD_RESP_SLVERR 2'b10

`endif

// [pcd_pkg.sv]
// Types shared by the port C change detector.
// Assumes pcd_defines.svh is available on the include path.
`include "pcd_defines.svh"

package pcd_pkg;
  typedef struct packed {
    logic [`PCD_PINS-1:0] rise_en;
    logic [`PCD_PINS-1:0] fall_en;
  } pcd_edge_cfg_t;

  typedef struct packed {
    logic awvalid;
    logic [`PCD_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`PCD_ADDR_W-1:0] araddr;
    logic rready;
  } pcd_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pcd_axi_rsp_t;
endpackage

// [pcd_change_detect_tb.sv]
// Self-checking bench for the port C change detector, large and small variants side by side.
// Assumes pcd_pkg and pcd_defines.svh are compiled first; the bench is the AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none
`include "pcd_defines.svh"
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module pcd_change_detect_tb;
  import pcd_pkg::*;
  logic aclk;
  logic aresetn;
  pcd_axi_req_t req;
  pcd_axi_rsp_t rsp;
  pcd_axi_rsp_t rsp_s;
  logic [7:0] pins;
  logic flag, flag_s, wake, wake_s, irq, irq_s;
  int n_fail;
  int num_checks;
  logic [31:0] rd_d;
  logic [31:0] rd_ds;
  logic [1:0] rd_r;
  logic [1:0] wr_b;
  logic [3:0] wr_strb;

  pcd_change_detect #(.LARGE_VARIANT(1'b1)) uut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
    .axi_rsp(rsp), .third_port_pin(pins), .shared_change_irq_flag(flag), .wake_req(wake), .irq(irq));
  // The small variant sees every request too, so its missing pins show up in the same reads.
  pcd_change_detect #(.LARGE_VARIANT(1'b0)) uut_small (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
    .axi_rsp(rsp_s), .third_port_pin(pins), .shared_change_irq_flag(flag_s), .wake_req(wake_s),
    .irq(irq_s));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // Address and data are offered together; each is dropped at the edge that takes it.
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bit aw_ok;
    bit w_ok;
    bit b_ok;
    @(posedge aclk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= wr_strb;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    while (!b_ok) begin
      @(posedge aclk);
      if (aw_ok && w_ok && rsp.bvalid) begin
        b_ok = 1'b1;
        wr_b = rsp.bresp;
        req.bready <= 1'b0;
      end
      if (!aw_ok && rsp.awready) begin
        aw_ok = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w_ok && rsp.wready) begin
        w_ok = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [4:0] a);
    bit ar_ok;
    bit r_ok;
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    ar_ok = 1'b0;
    r_ok = 1'b0;
    while (!r_ok) begin
      @(posedge aclk);
      if (!ar_ok && rsp.arready) begin
        ar_ok = 1'b1;
        req.arvalid <= 1'b0;
      end else if (ar_ok && rsp.rvalid) begin
        r_ok = 1'b1;
        rd_d = rsp.rdata;
        rd_ds = rsp_s.rdata;
        rd_r = rsp.rresp;
        req.rready <= 1'b0;
      end
    end
  endtask

  task automatic chk_rd(input logic [4:0] a, input logic [7:0] eb, input logic [7:0] es);
    rd(a);
    `CHK("read data", {24'h000000, eb}, rd_d)
    `CHK("read data small", {24'h000000, es}, rd_ds)
    `CHK("read response", `PCD_RESP_OKAY, rd_r)
  endtask

  // Five edges cover the two synchroniser stages and the compare stage with margin.
  task automatic set_pins(input logic [7:0] v);
    @(posedge aclk);
    pins <= v;
    repeat (5) @(posedge aclk);
  endtask

  initial begin
    aresetn = 1'b0;
    req = '0;
    pins = 8'h00;
    n_fail = 0;
    num_checks = 0;
    wr_strb = 4'hf;
    do_reset();
    chk_rd(`PCD_OFF_RISE_EN, 8'h00, 8'h00);
    chk_rd(`PCD_OFF_FALL_EN, 8'h00, 8'h00);
    chk_rd(`PCD_OFF_FLAGS, 8'h00, 8'h00);
    wr(`PCD_OFF_RISE_EN, 32'h000000f0);
    `CHK("write response", `PCD_RESP_OKAY, wr_b)
    wr(`PCD_OFF_FALL_EN, 32'h000000cf);
    chk_rd(`PCD_OFF_RISE_EN, 8'hf0, 8'h30);
    chk_rd(`PCD_OFF_FALL_EN, 8'hcf, 8'h0f);
    set_pins(8'hff);
    `CHK("shared flag", 2'b11, {flag, flag_s})
    chk_rd(`PCD_OFF_FLAGS, 8'hf0, 8'h30);
    chk_rd(`PCD_OFF_IRQ_STAT, 8'h01, 8'h01);
    `CHK("irq masked", 2'b00, {irq, irq_s})
    wr(`PCD_OFF_FLAGS, 32'h00000000);
    chk_rd(`PCD_OFF_FLAGS, 8'h00, 8'h00);
    `CHK("shared flag clear", 2'b00, {flag, flag_s})
    wr(`PCD_OFF_IRQ_EN, 32'h00000001);
    `CHK("irq raised", 2'b11, {irq, irq_s})
    wr(`PCD_OFF_IRQ_CLR, 32'h00000001);
    `CHK("irq cleared", 2'b00, {irq, irq_s})
    chk_rd(`PCD_OFF_IRQ_CLR, 8'h00, 8'h00);
    wr(`PCD_OFF_IRQ_EN, 32'h00000000);
    wr(`PCD_OFF_CTRL, 32'h00000001);
    set_pins(8'h00);
    `CHK("wake", 2'b11, {wake, wake_s})
    `CHK("irq masked again", 2'b00, {irq, irq_s})
    chk_rd(`PCD_OFF_FLAGS, 8'hcf, 8'h0f);
    chk_rd(`PCD_OFF_CTRL, 8'h03, 8'h03);
    wr(`PCD_OFF_FLAGS, 32'h000000fe);
    chk_rd(`PCD_OFF_FLAGS, 8'hce, 8'h0e);
    wr(`PCD_OFF_FLAGS, 32'h000000ff);
    chk_rd(`PCD_OFF_FLAGS, 8'hce, 8'h0e);
    wr_strb = 4'he;
    wr(`PCD_OFF_FLAGS, 32'h00000000);
    wr_strb = 4'hf;
    chk_rd(`PCD_OFF_FLAGS, 8'hce, 8'h0e);
    set_pins(8'h01);
    chk_rd(`PCD_OFF_FLAGS, 8'hce, 8'h0e);
    // The falling edge on pin 0 reaches the flag logic in the same cycle as the clear below.
    @(posedge aclk);
    pins <= 8'h00;
    @(posedge aclk);
    wr(`PCD_OFF_FLAGS, 32'h00000000);
    chk_rd(`PCD_OFF_FLAGS, 8'h01, 8'h01);
    rd(5'h1c);
    `CHK("unmapped response", `PCD_RESP_SLVERR, rd_r)
    `CHK("unmapped data", 32'h00000000, rd_d)
    wr(5'h1c, 32'h00000000);
    `CHK("unmapped write response", `PCD_RESP_SLVERR, wr_b)
    do_reset();
    chk_rd(`PCD_OFF_RISE_EN, 8'h00, 8'h00);
    chk_rd(`PCD_OFF_FALL_EN, 8'h00, 8'h00);
    chk_rd(`PCD_OFF_FLAGS, 8'h00, 8'h00);
    `CHK("flag after reset", 2'b00, {flag, flag_s})
    `CHK("irq after reset", 2'b00, {irq, irq_s})
    print_verdict();
  end

  // The sequence needs well under two hundred cycles; three thousand means something hung.
  initial begin
    #120000;
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
